// ==== rtl/corr_wake_pkg.sv ====
// Package: register map, reset values and carriers for the threshold/wake block
package corr_wake_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [5:0] OFFS_THRESH_LOW = 6'h19;
    localparam logic [5:0] OFFS_THRESH_HIGH = 6'h1A;
    localparam logic [5:0] OFFS_WAKE_ENABLE = 6'h1C;
    localparam logic [5:0] OFFS_WAKE_STATUS = 6'h1D;

    // ------------------------------------------------------------
    // Reset values and field layout
    // ------------------------------------------------------------
    localparam logic [6:0] RESET_THRESH_LOW = 7'h08;
    localparam logic [6:0] RESET_THRESH_HIGH = 7'h38;
    localparam logic RESET_WAKE_ENABLE = 1'b0;
    localparam logic RESET_WAKE_STATUS = 1'b1;
    localparam int WAKE_BIT_POS = 0;
    localparam int THRESH_MSB = 6;

    // ------------------------------------------------------------
    // Serial frame layout and link states
    // ------------------------------------------------------------
    localparam logic [3:0] FRAME_BITS = 4'h8;
    localparam int ADDR_BITS = 6;

    // Request handed from link domain to core domain
    typedef struct packed {
        logic write;
        logic [5:0] addr;
        logic [7:0] data;
    } reg_req_t;

    typedef enum logic [1:0] {
        LINK_CMD = 2'b00,
        LINK_DATA = 2'b01
    } link_state_t;

endpackage

// ==== rtl/corr_wake_regs.sv ====
// Correlator threshold and wakeup register slice behind the serial link
`timescale 1ns/1ps
`default_nettype none

module corr_wake_regs (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    input wire logic power_down_pin_i,
    input wire logic ready_i,
    input wire logic link_clk_i,
    input wire logic link_sel_n_i,
    input wire logic link_mosi_i,
    output logic link_miso_o,
    output logic link_miso_oe_n_o,
    output logic [6:0] thresh_high_o,
    output logic [6:0] thresh_low_o,
    output logic wake_irq_o
);

    // ------------------------------------------------------------
    // Pin synchronisers into core clock
    // ------------------------------------------------------------
    logic pd_meta, pd_sync, rdy_meta, rdy_sync, awake_q;
    logic thresh_wr_q;
    // Both pins are asynchronous; second stage alone is read
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            pd_meta <= 1'b1;
            pd_sync <= 1'b1;
            rdy_meta <= 1'b0;
            rdy_sync <= 1'b0;
        end else if (clk_en_i) begin
            pd_meta <= power_down_pin_i;
            pd_sync <= pd_meta;
            rdy_meta <= ready_i;
            rdy_sync <= rdy_meta;
        end
    end

    logic wake_event;
    assign wake_event = !pd_sync && rdy_sync && !awake_q;
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            awake_q <= 1'b0;
        end else if (clk_en_i) begin
            awake_q <= !pd_sync && rdy_sync;
        end
    end

    // ------------------------------------------------------------
    // Link domain: 8-bit command byte then 8-bit data byte
    // ------------------------------------------------------------
    // Command byte: bit7 write, bit6 unused, bits5:0 address, MSB first.
    // Frame logic is cleared by select going high, since the link clock stops.
    corr_wake_pkg::link_state_t link_state;
    logic [3:0] bit_cnt;
    logic [7:0] shift_in;
    logic [7:0] shift_out;
    logic cmd_write;
    logic [5:0] cmd_addr;
    corr_wake_pkg::reg_req_t link_req;
    logic req_tgl, rd_tgl;
    logic [7:0] rd_snapshot;

    // Reset as well as select clears it: the link clock may never tick before a frame
    always_ff @(posedge link_clk_i or posedge link_sel_n_i or posedge reset_i) begin
        if (link_sel_n_i || reset_i) begin
            link_state <= corr_wake_pkg::LINK_CMD;
            bit_cnt <= 4'h0;
            shift_in <= 8'h00;
        end else begin
            shift_in <= {shift_in[6:0], link_mosi_i};
            if (bit_cnt == corr_wake_pkg::FRAME_BITS - 4'h1) begin
                bit_cnt <= 4'h0;
                link_state <= corr_wake_pkg::LINK_DATA;
            end else begin
                bit_cnt <= bit_cnt + 4'h1;
            end
        end
    end

    // Command latch and request toggle; survives frame end for the core side
    always_ff @(posedge link_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cmd_write <= 1'b0;
            cmd_addr <= 6'h00;
            link_req <= '0;
            req_tgl <= 1'b0;
            rd_tgl <= 1'b0;
        end else if (!link_sel_n_i && bit_cnt == corr_wake_pkg::FRAME_BITS - 4'h1) begin
            if (link_state == corr_wake_pkg::LINK_CMD) begin
                cmd_write <= shift_in[6];
                cmd_addr <= {shift_in[4:0], link_mosi_i};
                // Reads are reported at command end so read-clear follows
                if (!shift_in[6]) begin
                    rd_tgl <= !rd_tgl;
                    link_req <= '{write: 1'b0, addr: {shift_in[4:0], link_mosi_i},
                                  data: 8'h00};
                end
            end else if (cmd_write) begin
                link_req <= '{write: 1'b1, addr: cmd_addr, data: {shift_in[6:0], link_mosi_i}};
                req_tgl <= !req_tgl;
            end
        end
    end

    // Read data shifts out MSB first on the falling edge during the data byte
    always_ff @(negedge link_clk_i or posedge link_sel_n_i or posedge reset_i) begin
        if (link_sel_n_i || reset_i) begin
            shift_out <= 8'h00;
        end else if (link_state == corr_wake_pkg::LINK_DATA && bit_cnt == 4'h0
                     && !cmd_write) begin
            shift_out <= rd_snapshot;
        end else begin
            shift_out <= {shift_out[6:0], 1'b0};
        end
    end
    assign link_miso_o = shift_out[7];
    // Active-low enable: drive only during a read data byte
    assign link_miso_oe_n_o = link_sel_n_i || link_state != corr_wake_pkg::LINK_DATA || cmd_write;

    // ------------------------------------------------------------
    // Core domain: crossing of toggles, register file
    // ------------------------------------------------------------
    logic [2:0] req_sync, rd_sync;
    logic wr_strobe, rd_strobe;
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            req_sync <= 3'h0;
            rd_sync <= 3'h0;
        end else if (clk_en_i) begin
            req_sync <= {req_sync[1:0], req_tgl};
            rd_sync <= {rd_sync[1:0], rd_tgl};
        end
    end
    // Request word is stable well before its toggle arrives here
    assign wr_strobe = clk_en_i && (req_sync[2] != req_sync[1]) && link_req.write;
    assign rd_strobe = clk_en_i && (rd_sync[2] != rd_sync[1]);

    logic [6:0] thresh_high, thresh_low;
    logic wake_enable, wake_status;

    // top bit dropped, reads as zero
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            thresh_high <= corr_wake_pkg::RESET_THRESH_HIGH;
        end else if (wr_strobe && link_req.addr == corr_wake_pkg::OFFS_THRESH_HIGH) begin
            thresh_high <= link_req.data[corr_wake_pkg::THRESH_MSB:0];
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            thresh_low <= corr_wake_pkg::RESET_THRESH_LOW;
        end else if (wr_strobe && link_req.addr == corr_wake_pkg::OFFS_THRESH_LOW) begin
            thresh_low <= link_req.data[corr_wake_pkg::THRESH_MSB:0];
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            wake_enable <= corr_wake_pkg::RESET_WAKE_ENABLE;
        end else if (wr_strobe && link_req.addr == corr_wake_pkg::OFFS_WAKE_ENABLE) begin
            wake_enable <= link_req.data[corr_wake_pkg::WAKE_BIT_POS];
        end
    end

    // set on wake, set beats read-clear
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            wake_status <= corr_wake_pkg::RESET_WAKE_STATUS;
        end else if (clk_en_i && wake_event) begin
            wake_status <= 1'b1;
        end else if (rd_strobe && link_req.addr == corr_wake_pkg::OFFS_WAKE_STATUS) begin
            wake_status <= 1'b0;
        end
    end

    // Read mux registered in core domain; host gets value captured
    // threshold, enable and status bit readback
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rd_snapshot <= 8'h00;
        end else if (rd_strobe) begin
            case (link_req.addr)
                corr_wake_pkg::OFFS_THRESH_HIGH: rd_snapshot <= {1'b0, thresh_high};
                corr_wake_pkg::OFFS_THRESH_LOW: rd_snapshot <= {1'b0, thresh_low};
                corr_wake_pkg::OFFS_WAKE_ENABLE: rd_snapshot <= {7'h00, wake_enable};
                corr_wake_pkg::OFFS_WAKE_STATUS: rd_snapshot <= {7'h00, wake_status};
                default: rd_snapshot <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            thresh_high_o <= corr_wake_pkg::RESET_THRESH_HIGH;
            thresh_low_o <= corr_wake_pkg::RESET_THRESH_LOW;
            thresh_wr_q <= 1'b0;
        end else if (clk_en_i) begin
            thresh_high_o <= thresh_high;
            thresh_low_o <= thresh_low;
            thresh_wr_q <= wr_strobe;
        end
    end

    assign wake_irq_o = wake_status && wake_enable;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_wake_seen;
        clk_en_i && wake_event;
    endsequence

    property p_wake_sets;
        @(posedge sys_clk_i) disable iff (reset_i) s_wake_seen |=> wake_status;
    endproperty
    a_wake_sets: assert property (p_wake_sets) else $error("wake did not set status");

    property p_read_clears;
        @(posedge sys_clk_i) disable iff (reset_i)
            rd_strobe && link_req.addr == corr_wake_pkg::OFFS_WAKE_STATUS && !wake_event
            |=> !wake_status;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("read did not clear");

    property p_status_ro;
        @(posedge sys_clk_i) disable iff (reset_i)
            !wake_event && !rd_strobe |=> $stable(wake_status);
    endproperty
    a_status_ro: assert property (p_status_ro) else $error("status changed by write");

    property p_irq_gate;
        @(posedge sys_clk_i) disable iff (reset_i) wake_irq_o |-> wake_status && wake_enable;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without cause");

    property p_high_out;
        @(posedge sys_clk_i) disable iff (reset_i)
            clk_en_i && thresh_wr_q |=> thresh_high_o == $past(thresh_high);
    endproperty
    a_high_out: assert property (p_high_out) else $error("high threshold not passed");

    property p_high_msb;
        @(posedge sys_clk_i) disable iff (reset_i) rd_strobe |=> !rd_snapshot[7];
    endproperty
    a_high_msb: assert property (p_high_msb) else $error("reserved bit set");

    property p_wake_cond;
        @(posedge sys_clk_i) disable iff (reset_i) wake_event |-> !pd_sync && rdy_sync;
    endproperty
    a_wake_cond: assert property (p_wake_cond) else $error("wake without release");

    property p_status_read;
        @(posedge sys_clk_i) disable iff (reset_i)
            rd_strobe && link_req.addr == corr_wake_pkg::OFFS_WAKE_STATUS
            |=> rd_snapshot == {7'h00, $past(wake_status)};
    endproperty
    a_status_read: assert property (p_status_read) else $error("status readback wrong");

    property p_low_write;
        @(posedge sys_clk_i) disable iff (reset_i)
            wr_strobe && link_req.addr == corr_wake_pkg::OFFS_THRESH_LOW
            |=> thresh_low == $past(link_req.data[6:0]);
    endproperty
    a_low_write: assert property (p_low_write) else $error("low threshold not written");

endmodule

`default_nettype wire

// ==== tb/host_link_model.sv ====
// Host side model: drives serial frames into the register slice
`timescale 1ns/1ps
`default_nettype none

module host_link_model (
    output logic link_clk_o,
    output logic link_sel_n_o,
    output logic link_mosi_o,
    input wire logic link_miso_i,
    input wire logic link_miso_oe_n_i
);
    // ------------------------------------------------------------
    // Frame engine
    // ------------------------------------------------------------
    localparam time HALF = 15ns;
    logic [7:0] rd_data;
    event rd_ev;

    // Idle: clock parked high and still, select released
    initial begin
        link_clk_o = 1'b1;
        link_sel_n_o = 1'b1;
        link_mosi_o = 1'b0;
    end

    // One byte MSB first: drive on falling edge, both sides sample on rising
    task automatic shift_byte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            link_clk_o = 1'b0;
            link_mosi_o = tx[i];
            #HALF;
            link_clk_o = 1'b1;
            // Released line has no pull: it shows the inverse, never a clean bit
            rx[i] = link_miso_oe_n_i ? ~link_miso_i : link_miso_i;
            #HALF;
        end
    endtask

    // Command byte then data byte; reads stall the clock so the core can snapshot
    task automatic xfer(input logic wr, input logic [5:0] addr, input logic [7:0] wdata);
        logic [7:0] tx;
        logic [7:0] rx;
        tx = wdata;
        if (addr == 6'h1A) tx[7] = 1'b0;
        if (addr == 6'h1C) tx[7:1] = 7'h00;
        link_sel_n_o = 1'b0;
        #HALF;
        // Write flag in bit 7, bit 6 unused, address below
        shift_byte({wr, 1'b0, addr}, rx);
        if (!wr) #(HALF * 20);
        shift_byte(tx, rx);
        // No pull on the line: show the inverse rather than a stale bit
        link_mosi_o = ~link_mosi_o;
        #HALF;
        link_sel_n_o = 1'b1;
        // Gap of at least eight core cycles before the next frame
        #(HALF * 24);
        if (!wr) begin
            rd_data = rx;
            -> rd_ev;
        end
    endtask
endmodule

`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the threshold and wakeup register slice
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic sys_clk = 1'b0;
    logic reset = 1'b0;
    logic clk_en = 1'b1;
    logic power_down = 1'b1;
    logic ready = 1'b0;
    wire logic link_clk;
    wire logic link_sel_n;
    wire logic link_mosi;
    wire logic link_miso;
    wire logic link_miso_oe_n;
    wire logic [6:0] thresh_high;
    wire logic [6:0] thresh_low;
    wire logic wake_irq;
    int num_errors = 0;
    int compares = 0;
    logic [7:0] exp_q[$];
    logic [7:0] val;

    // Core clock, 40 ns period
    always #20 sys_clk = ~sys_clk;

    corr_wake_regs dut (.sys_clk_i(sys_clk), .reset_i(reset), .clk_en_i(clk_en),
        .power_down_pin_i(power_down), .ready_i(ready), .link_clk_i(link_clk),
        .link_sel_n_i(link_sel_n), .link_mosi_i(link_mosi), .link_miso_o(link_miso),
        .link_miso_oe_n_o(link_miso_oe_n), .thresh_high_o(thresh_high),
        .thresh_low_o(thresh_low), .wake_irq_o(wake_irq));

    host_link_model host (.link_clk_o(link_clk), .link_sel_n_o(link_sel_n),
        .link_mosi_o(link_mosi), .link_miso_i(link_miso), .link_miso_oe_n_i(link_miso_oe_n));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rd(input logic [5:0] addr, input logic [7:0] exp);
        exp_q.push_back(exp);
        host.xfer(1'b0, addr, 8'h00);
    endtask

    task automatic wr(input logic [5:0] addr, input logic [7:0] data);
        host.xfer(1'b1, addr, data);
    endtask

    // Inputs move just after the rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic summarize();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Monitor: each finished read is matched to the oldest note
    initial begin
        forever begin
            @(host.rd_ev);
            check("rdata", exp_q.pop_front(), host.rd_data);
        end
    end

    // Watchdog, well beyond the roughly 40 us the sequence needs
    initial begin
        #200us;
        num_errors++;
        summarize();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'hC5F577BB));
        // Reset rises after time zero so every async-reset flop sees the edge
        #1;
        reset = 1'b1;
        tick(6);
        reset = 1'b0;
        tick(2);
        check("thr_high", 8'h38, {1'b0, thresh_high});
        check("thr_low", 8'h08, {1'b0, thresh_low});
        check("irq", 8'h00, {7'h00, wake_irq});
        check("oe_n", 8'h01, {7'h00, link_miso_oe_n});
        rd(6'h1A, 8'h38);
        rd(6'h19, 8'h08);
        rd(6'h1C, 8'h00);
        rd(6'h1D, 8'h01);
        rd(6'h1D, 8'h00);
        rd(6'h3F, 8'h00);
        // Code-length thresholds first, then random ones
        for (int i = 0; i < 6; i++) begin
            val = (i < 2) ? (i == 0 ? 8'h40 : 8'h20) : 8'($urandom_range(127));
            wr(6'h1A, val);
            wr(6'h19, val ^ 8'h7F);
            rd(6'h1A, val);
            rd(6'h19, val ^ 8'h7F);
            check("thr_high", val, {1'b0, thresh_high});
            check("thr_low", val ^ 8'h7F, {1'b0, thresh_low});
        end
        wr(6'h1D, 8'hFF);
        rd(6'h1D, 8'h00);
        // Wake with the interrupt enabled: needs both release and ready
        wr(6'h1C, 8'h01);
        rd(6'h1C, 8'h01);
        check("irq", 8'h00, {7'h00, wake_irq});
        power_down = 1'b0;
        tick(8);
        check("irq", 8'h00, {7'h00, wake_irq});
        ready = 1'b1;
        tick(8);
        check("irq", 8'h01, {7'h00, wake_irq});
        rd(6'h1D, 8'h01);
        check("irq", 8'h00, {7'h00, wake_irq});
        // Wake again with the interrupt disabled
        wr(6'h1C, 8'h00);
        power_down = 1'b1;
        ready = 1'b0;
        tick(8);
        power_down = 1'b0;
        ready = 1'b1;
        tick(8);
        check("irq", 8'h00, {7'h00, wake_irq});
        rd(6'h1D, 8'h01);
        // Frozen core must miss a full wake cycle on the pins
        clk_en = 1'b0;
        power_down = 1'b1;
        ready = 1'b0;
        tick(8);
        power_down = 1'b0;
        ready = 1'b1;
        tick(8);
        clk_en = 1'b1;
        tick(8);
        rd(6'h1D, 8'h00);
        tick(10);
        summarize();
    end
endmodule

`default_nettype wire
